//--- design/pbcs_pkg.sv
// Overview of operation
// RULE_01 - Loop settings accept writes only while loop enable is zero
// RULE_02 - Zero reference divider or multiplier acts exactly like one
// RULE_03 - Zero range multiplier disables loop and forces oscillator clock
// RULE_04 - Base source select chooses oscillator or divided VCO clock
// RULE_05 - Switch waits three cycles of each clock, output held static
// RULE_06 - Transition output divided by two forms the base clock
// RULE_07 - Divided VCO clock cannot be selected while loop is off
// RULE_08 - Loop enable cannot clear while divided VCO clock selected
// RULE_09 - One write never changes loop enable and source select together
// RULE_10 - Base clock has fifty percent duty at twice bus rate
// RULE_11 - Interrupt output is driven by lock detector events
// RULE_12 - Loop reference clock is a buffered oscillator clock
// RULE_13 - Software loads P, E, N, L and R binary values
// RULE_14 - Center frequency equals L times two power E times 125kHz
// RULE_15 - Software checks center frequency lies within half range step
// RULE_16 - Lock toggle sets change flag; control register read clears it
// RULE_17 - Writing zero to range register disables loop, clears select
// RULE_18 - Select change is synchronised in each clock domain separately
package pbcs_pkg;
    // ==========================================================
    // Clock and timing
    localparam int unsigned CLK_HZ       = 20_000_000;
    localparam int unsigned F_NOM_KHZ    = 125;
    localparam int unsigned F_NOM_HZ     = F_NOM_KHZ * 1000;
    localparam logic [1:0]  SWITCH_EDGES = 2'h3;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_MUL    = 8'h04;
    localparam logic [7:0] OFS_RANGE  = 8'h08;
    localparam logic [7:0] OFS_RDIV   = 8'h0C;
    localparam logic [7:0] OFS_STAT   = 8'h10;
    localparam logic [7:0] OFS_MASK   = 8'h14;
    localparam logic [7:0] OFS_CENTER = 8'h18;
    // ==========================================================
    // Control register fields
    localparam int unsigned CTL_EN   = 0;
    localparam int unsigned CTL_SEL  = 1;
    localparam int unsigned CTL_PRE  = 2;
    localparam int unsigned CTL_VPR  = 4;
    localparam int unsigned CTL_FLAG = 6;
    localparam int unsigned CTL_LOCK = 7;
    // ==========================================================
    // Interrupt status bits
    localparam int unsigned IRQ_LOCK = 0;
    localparam int unsigned IRQ_SWD  = 1;
    localparam int unsigned IRQ_W    = 2;
    // ==========================================================
    // Reset values
    localparam logic [11:0] RST_MUL   = 12'h040;
    localparam logic [7:0]  RST_RANGE = 8'h40;
    localparam logic [3:0]  RST_RDIV  = 4'h1;
    localparam logic        RST_EN    = 1'b1;
endpackage : pbcs_pkg

//--- design/pbcs_sw_if.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Link between control and source switch
interface pbcs_sw_if;
    logic req_sel;
    logic cur_sel;
    logic busy;
    logic src_edge;
    modport ctrl (output req_sel, input cur_sel, input busy, input src_edge);
    modport sw   (input req_sel, output cur_sel, output busy, output src_edge);
endinterface : pbcs_sw_if
`default_nettype wire

//--- design/pbcs_src_switch.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Glitch-free source switch, edges seen on ref_clk samples
module pbcs_src_switch (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Source clocks
    input  wire logic osc_clock,
    input  wire logic divided_vco_clock,
    // Control side
    pbcs_sw_if.sw     sw
);
    logic       osc_q;
    logic       vco_q;
    logic [1:0] cnt_osc;
    logic [1:0] cnt_vco;
    logic       osc_rise;
    logic       vco_rise;

    // Rising edges of each source
    assign osc_rise = osc_clock & ~osc_q;
    assign vco_rise = divided_vco_clock & ~vco_q;

    // Edge history
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            osc_q <= 1'b0;
            vco_q <= 1'b0;
        end else begin
            osc_q <= osc_clock;
            vco_q <= divided_vco_clock;
        end
    end

    // Per-domain edge counting during a change
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sw.busy    <= 1'b0;
            sw.cur_sel <= 1'b0;
            cnt_osc    <= 2'h0;
            cnt_vco    <= 2'h0;
        end else if (!sw.busy) begin
            if (sw.req_sel != sw.cur_sel) begin
                sw.busy <= 1'b1;
                cnt_osc <= 2'h0;
                cnt_vco <= 2'h0;
            end
        end else if (cnt_osc == pbcs_pkg::SWITCH_EDGES && cnt_vco == pbcs_pkg::SWITCH_EDGES) begin
            sw.busy    <= 1'b0;  // see RULE_05
            sw.cur_sel <= ~sw.cur_sel;
        end else begin
            if (osc_rise && cnt_osc != pbcs_pkg::SWITCH_EDGES) begin
                cnt_osc <= cnt_osc + 2'h1;  // see RULE_18
            end
            if (vco_rise && cnt_vco != pbcs_pkg::SWITCH_EDGES) begin
                cnt_vco <= cnt_vco + 2'h1;  // see RULE_18
            end
        end
    end

    // Transition output edges, none while held
    assign sw.src_edge = !sw.busy && (sw.cur_sel ? vco_rise : osc_rise);  // see RULE_05
endmodule : pbcs_src_switch
`default_nettype wire

//--- design/pbcs_div2.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Divide by two of the transition output
module pbcs_div2 (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Source edge in, base clock out
    input  wire logic src_edge,
    output logic      base_clock_out
);
    // Toggle on every source rising edge
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            base_clock_out <= 1'b0;
        end else if (src_edge) begin
            base_clock_out <= ~base_clock_out;  // see RULE_06, see RULE_10
        end
    end
endmodule : pbcs_div2
`default_nettype wire

//--- design/pbcs_top.sv
// Our own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Loop programming and base clock select, AHB-Lite slave
module pbcs_top #(
    parameter int unsigned MUL_W  = 12,
    parameter int unsigned RDIV_W = 4
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    // AHB-Lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // Clock sources and lock detector
    input  wire logic              osc_clock,
    input  wire logic              divided_vco_clock,
    input  wire logic              lock_in,
    // Clock outputs
    output logic                   base_clock_out,
    output logic                   loop_reference_clock,
    // Interrupt
    output logic                   clock_gen_irq,
    // Analog loop settings
    output logic                   loop_active,
    output logic [1:0]             prescaler_power,
    output logic [1:0]             vco_power_range_field,
    output logic [MUL_W-1:0]       eff_multiplier,
    output logic [RDIV_W-1:0]      eff_ref_divider,
    output logic [7:0]             vco_range_value
);
    // ==========================================================
    // Declarations
    logic                  loop_enable;
    logic                  base_src_select;
    logic                  lock_change_flag;
    logic                  lock_q;
    logic                  lock_toggle;
    logic [MUL_W-1:0]      multiplier;
    logic [7:0]            vco_range;
    logic [RDIV_W-1:0]     ref_divider;
    logic [pbcs_pkg::IRQ_W-1:0] irq_status;
    logic [pbcs_pkg::IRQ_W-1:0] irq_mask;
    logic [31:0]           center_hz;
    logic                  busy_q;
    logic                  switch_done;
    logic                  accept;
    logic                  wr_pend;
    logic [7:0]            wr_addr;
    logic                  wr_ctl;
    logic                  wr_mul;
    logic                  wr_rng;
    logic                  wr_rdv;
    logic                  wr_stat;
    logic                  wr_mask;
    logic                  rd_ctl;
    logic [7:0]            rd_addr;
    logic [31:0]           next_rdata;
    logic                  wd_en;
    logic                  wd_sel;
    pbcs_sw_if             sw_if ();

    // ==========================================================
    // Bus slave: always ready, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign accept    = hsel && hready && htrans[1];
    assign rd_addr   = haddr[7:0];
    assign rd_ctl    = accept && !hwrite && rd_addr == pbcs_pkg::OFS_CTRL;

    // Address phase capture for writes
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else if (hready) begin
            wr_pend <= accept && hwrite;
            wr_addr <= haddr[7:0];
        end
    end

    // Write strobes in the data phase
    assign wr_ctl  = wr_pend && wr_addr == pbcs_pkg::OFS_CTRL;
    assign wr_mul  = wr_pend && wr_addr == pbcs_pkg::OFS_MUL;
    assign wr_rng  = wr_pend && wr_addr == pbcs_pkg::OFS_RANGE;
    assign wr_rdv  = wr_pend && wr_addr == pbcs_pkg::OFS_RDIV;
    assign wr_stat = wr_pend && wr_addr == pbcs_pkg::OFS_STAT;
    assign wr_mask = wr_pend && wr_addr == pbcs_pkg::OFS_MASK;
    assign wd_en   = hwdata[pbcs_pkg::CTL_EN];
    assign wd_sel  = hwdata[pbcs_pkg::CTL_SEL];

    // Read multiplexer, unmapped reads give zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (rd_addr)
            pbcs_pkg::OFS_CTRL: begin
                next_rdata[pbcs_pkg::CTL_EN]        = loop_enable;
                next_rdata[pbcs_pkg::CTL_SEL]       = base_src_select;
                next_rdata[pbcs_pkg::CTL_PRE+:2]    = prescaler_power;
                next_rdata[pbcs_pkg::CTL_VPR+:2]    = vco_power_range_field;
                next_rdata[pbcs_pkg::CTL_FLAG]      = lock_change_flag;
                next_rdata[pbcs_pkg::CTL_LOCK]      = lock_q;
            end
            pbcs_pkg::OFS_MUL:    next_rdata[MUL_W-1:0]  = multiplier;
            pbcs_pkg::OFS_RANGE:  next_rdata[7:0]        = vco_range;
            pbcs_pkg::OFS_RDIV:   next_rdata[RDIV_W-1:0] = ref_divider;
            pbcs_pkg::OFS_STAT:   next_rdata[pbcs_pkg::IRQ_W-1:0] = irq_status;
            pbcs_pkg::OFS_MASK:   next_rdata[pbcs_pkg::IRQ_W-1:0] = irq_mask;
            pbcs_pkg::OFS_CENTER: next_rdata = center_hz;
            default:              next_rdata = 32'h0000_0000;
        endcase
    end

    // Read data registered for the data phase
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (accept && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // ==========================================================
    // Loop enable and source select with mutual protection
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            loop_enable     <= pbcs_pkg::RST_EN;
            base_src_select <= 1'b0;
        end else if (wr_ctl) begin
            // Clear refused while the VCO clock is selected
            if (wd_en || !base_src_select) begin
                loop_enable <= wd_en;  // see RULE_08, see RULE_09
            end
            // Set only while the enable is on and stays on
            if (!wd_sel) begin
                base_src_select <= 1'b0;
            end else if (loop_enable && wd_en && vco_range != 8'h00) begin
                base_src_select <= 1'b1;  // see RULE_07, see RULE_03, see RULE_09
            end
        end else if (wr_rng && !loop_enable && hwdata[7:0] == 8'h00) begin
            base_src_select <= 1'b0;  // see RULE_17
        end else if (vco_range == 8'h00) begin
            base_src_select <= 1'b0;  // see RULE_03
        end
    end

    // Prescaler and range power, frozen while the loop runs
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prescaler_power       <= 2'h0;
            vco_power_range_field <= 2'h0;
        end else if (wr_ctl && !loop_enable) begin
            prescaler_power       <= hwdata[pbcs_pkg::CTL_PRE+:2];  // see RULE_01
            vco_power_range_field <= hwdata[pbcs_pkg::CTL_VPR+:2];  // see RULE_01
        end
    end

    // Multiplier, range and reference divider, frozen while the loop runs
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            multiplier  <= MUL_W'(pbcs_pkg::RST_MUL);
            vco_range   <= pbcs_pkg::RST_RANGE;
            ref_divider <= RDIV_W'(pbcs_pkg::RST_RDIV);
        end else if (!loop_enable) begin
            if (wr_mul) begin
                multiplier <= hwdata[MUL_W-1:0];  // see RULE_01
            end
            if (wr_rng) begin
                vco_range <= hwdata[7:0];  // see RULE_01
            end
            if (wr_rdv) begin
                ref_divider <= hwdata[RDIV_W-1:0];  // see RULE_01
            end
        end
    end

    // ==========================================================
    // Settings presented to the analog loop
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            eff_multiplier  <= MUL_W'(pbcs_pkg::RST_MUL);
            eff_ref_divider <= RDIV_W'(pbcs_pkg::RST_RDIV);
            vco_range_value <= pbcs_pkg::RST_RANGE;
            loop_active     <= 1'b0;
            center_hz       <= 32'h0000_0000;
        end else begin
            eff_multiplier  <= (multiplier == '0) ? MUL_W'(1) : multiplier;  // see RULE_02
            eff_ref_divider <= (ref_divider == '0) ? RDIV_W'(1) : ref_divider;  // see RULE_02
            vco_range_value <= vco_range;
            loop_active     <= loop_enable && vco_range != 8'h00;  // see RULE_03, see RULE_17
            center_hz       <= 32'((32'(vco_range) << vco_power_range_field)
                                   * pbcs_pkg::F_NOM_HZ);  // see RULE_14
        end
    end

    // Reference clock passed straight from the oscillator
    assign loop_reference_clock = osc_clock;  // see RULE_12

    // ==========================================================
    // Lock detector: toggle flag and interrupt events
    assign lock_toggle = lock_in ^ lock_q;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            lock_q <= 1'b0;
        end else begin
            lock_q <= lock_in;
        end
    end

    // Change flag, a new toggle wins over the read clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            lock_change_flag <= 1'b0;
        end else if (lock_toggle) begin
            lock_change_flag <= 1'b1;  // see RULE_16
        end else if (rd_ctl) begin
            lock_change_flag <= 1'b0;  // see RULE_16
        end
    end

    // Sticky status, write one to clear, set wins
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irq_status <= '0;
            irq_mask   <= '0;
            busy_q     <= 1'b0;
        end else begin
            busy_q <= sw_if.busy;
            if (wr_mask) begin
                irq_mask <= hwdata[pbcs_pkg::IRQ_W-1:0];
            end
            for (int i = 0; i < pbcs_pkg::IRQ_W; i++) begin
                if ((i == pbcs_pkg::IRQ_LOCK && lock_toggle)
                    || (i == pbcs_pkg::IRQ_SWD && switch_done)) begin
                    irq_status[i] <= 1'b1;  // see RULE_11
                end else if (wr_stat && hwdata[i]) begin
                    irq_status[i] <= 1'b0;
                end
            end
        end
    end

    assign switch_done   = busy_q && !sw_if.busy;
    // Level interrupt from unmasked status
    assign clock_gen_irq = |(irq_status & irq_mask);  // see RULE_11

    // ==========================================================
    // Source switch and divider
    assign sw_if.req_sel = base_src_select;  // see RULE_04

    pbcs_src_switch u_switch (
        .ref_clk           (ref_clk),
        .rst_n             (rst_n),
        .osc_clock         (osc_clock),
        .divided_vco_clock (divided_vco_clock),
        .sw                (sw_if.sw)
    );

    pbcs_div2 u_div2 (
        .ref_clk        (ref_clk),
        .rst_n          (rst_n),
        .src_edge       (sw_if.src_edge),
        .base_clock_out (base_clock_out)
    );

    // ==========================================================
    // Assertions
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_prog_frozen: assert property (
        (wr_ctl || wr_mul || wr_rng || wr_rdv) && loop_enable
        |=> $stable(prescaler_power) && $stable(multiplier)
            && $stable(vco_range) && $stable(ref_divider))  // see RULE_01
        else $error("loop setting changed while loop enabled");

    a_zero_as_one: assert property (
        multiplier == '0 && ref_divider == '0
        |=> eff_multiplier == MUL_W'(1) && eff_ref_divider == RDIV_W'(1))  // see RULE_02
        else $error("zero divider or multiplier not taken as one");

    a_zero_range: assert property (
        vco_range == 8'h00 |=> !base_src_select && !loop_active)  // see RULE_03
        else $error("zero range left loop or vco source active");

    a_sel_follow: assert property (
        $changed(base_src_select) |=> sw_if.busy ##[1:1000] sw_if.cur_sel == base_src_select
            || !$stable(base_src_select))  // see RULE_04
        else $error("switch did not follow source select");

    a_hold_static: assert property (
        sw_if.busy && $past(sw_if.busy) |-> $stable(base_clock_out))  // see RULE_05
        else $error("base clock moved during transition");

    a_div_toggle: assert property (
        sw_if.src_edge |=> base_clock_out != $past(base_clock_out))  // see RULE_06
        else $error("base clock missed a source edge");

    a_sel_needs_en: assert property (
        base_src_select |-> loop_enable)  // see RULE_07
        else $error("vco source selected with loop off");

    a_no_en_clear: assert property (
        $fell(loop_enable) |-> !$past(base_src_select))  // see RULE_08
        else $error("loop enable cleared while vco source selected");

    a_not_both: assert property (
        !($changed(loop_enable) && $changed(base_src_select)))  // see RULE_09
        else $error("enable and select changed together");

    a_lock_irq: assert property (
        lock_toggle && irq_mask[pbcs_pkg::IRQ_LOCK] |=> clock_gen_irq)  // see RULE_11
        else $error("lock change raised no interrupt");

    a_flag_set: assert property (
        lock_toggle |=> lock_change_flag)  // see RULE_16
        else $error("lock toggle did not set change flag");

    a_flag_clear: assert property (
        rd_ctl && !lock_toggle |=> !lock_change_flag)  // see RULE_16
        else $error("control read did not clear change flag");

    c_to_vco: cover property (sw_if.busy ##[1:200] sw_if.cur_sel && !sw_if.busy);
    c_lock_flag: cover property (lock_toggle ##1 rd_ctl ##1 !lock_change_flag);
    c_zero_range: cover property (wr_rng && !loop_enable && hwdata[7:0] == 8'h00);
endmodule : pbcs_top
`default_nettype wire

//--- design/pbcs_unused_guard.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

//--- testbench/pbcs_src_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Far side: oscillator, divided VCO clock and lock detector
module pbcs_src_model #(
    parameter int OSC_HALF = 4,
    parameter int VCO_HALF = 3
) (
    // Timebase
    input  wire logic ref_clk,
    // Lock level asked for by the bench
    input  wire logic lock_req,
    // Clocks and lock level to the block
    output logic      osc_clock,
    output logic      divided_vco_clock,
    output logic      lock_in
);
    int oc = 0;
    int vc = 0;
    initial begin
        osc_clock = 1'b0;
        divided_vco_clock = 1'b0;
        lock_in = 1'b0;
    end
    // Both sources toggle from ref_clk counts, well below ref_clk/2
    always @(posedge ref_clk) begin
        oc <= (oc == OSC_HALF - 1) ? 0 : oc + 1;
        vc <= (vc == VCO_HALF - 1) ? 0 : vc + 1;
        if (oc == OSC_HALF - 1) osc_clock <= ~osc_clock;
        if (vc == VCO_HALF - 1) divided_vco_clock <= ~divided_vco_clock;
        lock_in <= lock_req; // Lock level is synchronous to ref_clk
    end
endmodule : pbcs_src_model
`default_nettype wire

//--- testbench/test_pll_base_clock_select.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Self-checking bench for loop programming and base clock select
module test_pll_base_clock_select;
    typedef struct {
        string       n;
        logic [31:0] e;
    } pbcs_exp_s;
    logic ref_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, lock_req = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic        rd_ph = 1'b0;
    logic [11:0] r;
    logic [31:0] hrdata;
    logic hreadyout, hresp, osc_clock, divided_vco_clock, lock_in, base_clock_out;
    logic loop_reference_clock, clock_gen_irq, loop_active;
    logic [1:0]  prescaler_power, vco_power_range_field;
    logic [11:0] eff_multiplier;
    logic [3:0]  eff_ref_divider;
    logic [7:0]  vco_range_value;
    wire logic   hready;
    pbcs_exp_s   exp_q[$];
    int          num_errors = 0;
    int          checks_done = 0;
    integer      seed = 32'hBA8A1959;
    assign hready = hreadyout;
    pbcs_top pbcs_top_i (.ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .osc_clock, .divided_vco_clock, .lock_in,
        .base_clock_out, .loop_reference_clock, .clock_gen_irq, .loop_active,
        .prescaler_power, .vco_power_range_field, .eff_multiplier, .eff_ref_divider,
        .vco_range_value);
    pbcs_src_model pbcs_src_model_i (.ref_clk, .lock_req, .osc_clock, .divided_vco_clock,
        .lock_in);
    // ==========================================================
    // Tasks
    task automatic check(input string n, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, exp, got);
        end
    endtask : check
    // One single transfer; a read notes its expected word
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        pbcs_exp_s x;
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge ref_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        if (!w) begin
            x.n = $sformatf("read %h", a);
            x.e = d;
            exp_q.push_back(x);
        end
        do @(posedge ref_clk); while (hready !== 1'b1);
    endtask : bus
    task automatic wait_irq;
        int t;
        for (t = 0; t < 400 && clock_gen_irq !== 1'b1; t++) @(posedge ref_clk);
        check("switch irq", 32'(clock_gen_irq), 32'h1);
    endtask : wait_irq
    // Counts high cycles and period of the base clock
    task automatic measure(input int per, input int hi);
        int t;
        int h;
        for (t = 0; t < 200 && base_clock_out !== 1'b0; t++) @(posedge ref_clk);
        for (t = 0; t < 200 && base_clock_out !== 1'b1; t++) @(posedge ref_clk);
        for (h = 0; h < 200 && base_clock_out === 1'b1; h++) @(posedge ref_clk);
        for (t = h; t < 400 && base_clock_out !== 1'b1; t++) @(posedge ref_clk);
        check("base high cycles", 32'(h), 32'(hi));
        check("base period", 32'(t), 32'(per));
    endtask : measure
    task automatic final_report;
        if (num_errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report
    // ==========================================================
    // Clock, watchdog and read monitor
    always #25 ref_clk = ~ref_clk;
    initial begin
        #2_000_000;
        num_errors++;
        final_report();
    end
    // Takes the oldest note whenever read data stands on the bus
    always @(posedge ref_clk) begin
        if (rd_ph && hready === 1'b1) begin
            check(exp_q[0].n, hrdata, exp_q[0].e);
            void'(exp_q.pop_front());
        end
        rd_ph <= hsel && htrans[1] && !hwrite && hready;
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        bus(0, pbcs_pkg::OFS_CTRL, 32'h01);
        bus(0, pbcs_pkg::OFS_RANGE, 32'h40);
        bus(1, 8'h1C, 32'hFF);
        bus(0, 8'h1C, 32'h0);
        bus(1, pbcs_pkg::OFS_MUL, 32'h123);
        bus(1, pbcs_pkg::OFS_CTRL, 32'h2D);
        bus(0, pbcs_pkg::OFS_MUL, 32'h40);
        bus(0, pbcs_pkg::OFS_CTRL, 32'h01);
        bus(1, pbcs_pkg::OFS_CTRL, 32'h00);
        bus(1, pbcs_pkg::OFS_CTRL, 32'h2E);
        bus(0, pbcs_pkg::OFS_CTRL, 32'h2C);
        check("loop_active", 32'(loop_active), 32'h0);
        check("prescaler", 32'(prescaler_power), 32'h3);
        check("vco power", 32'(vco_power_range_field), 32'h2);
        bus(0, pbcs_pkg::OFS_CENTER, (32'h40 << 2) * pbcs_pkg::F_NOM_HZ);
        // Random multipliers, zero treated as one
        repeat (4) begin
            r = 12'($random(seed));
            bus(1, pbcs_pkg::OFS_MUL, {20'h0, r});
            bus(0, pbcs_pkg::OFS_MUL, {20'h0, r});
            check("eff_multiplier", 32'(eff_multiplier), (r == 0) ? 32'h1 : 32'(r));
        end
        bus(1, pbcs_pkg::OFS_MUL, 32'h0);
        bus(1, pbcs_pkg::OFS_RDIV, 32'h0);
        bus(0, pbcs_pkg::OFS_RDIV, 32'h0);
        check("eff_multiplier", 32'(eff_multiplier), 32'h1);
        check("eff_ref_divider", 32'(eff_ref_divider), 32'h1);
        // Enable and select in one write, then select alone
        bus(1, pbcs_pkg::OFS_CTRL, 32'h2F);
        bus(0, pbcs_pkg::OFS_CTRL, 32'h2D);
        check("loop_active", 32'(loop_active), 32'h1);
        bus(1, pbcs_pkg::OFS_CTRL, 32'h2E);
        bus(0, pbcs_pkg::OFS_CTRL, 32'h2C);
        bus(1, pbcs_pkg::OFS_CTRL, 32'h2F);
        bus(1, pbcs_pkg::OFS_MASK, 32'h2);
        bus(1, pbcs_pkg::OFS_CTRL, 32'h2F);
        bus(0, pbcs_pkg::OFS_CTRL, 32'h2F);
        wait_irq();
        bus(0, pbcs_pkg::OFS_STAT, 32'h2);
        measure(12, 6);
        check("ref clock", 32'(loop_reference_clock), 32'(osc_clock));
        check("hresp", 32'(hresp), 32'h0);
        bus(1, pbcs_pkg::OFS_CTRL, 32'h2C);
        bus(0, pbcs_pkg::OFS_CTRL, 32'h2D);
        bus(1, pbcs_pkg::OFS_STAT, 32'h2);
        wait_irq();
        measure(16, 8);
        bus(1, pbcs_pkg::OFS_STAT, 32'h3);
        // Range zero keeps the divided clock away
        bus(1, pbcs_pkg::OFS_CTRL, 32'h2C);
        bus(1, pbcs_pkg::OFS_RANGE, 32'h0);
        bus(1, pbcs_pkg::OFS_CTRL, 32'h2D);
        bus(1, pbcs_pkg::OFS_CTRL, 32'h2F);
        bus(0, pbcs_pkg::OFS_CTRL, 32'h2D);
        check("loop_active", 32'(loop_active), 32'h0);
        check("range", 32'(vco_range_value), 32'h0);
        // Lock change: masked, then raised, read-cleared and cleared
        lock_req <= 1'b1;
        repeat (3) @(posedge ref_clk);
        bus(0, pbcs_pkg::OFS_STAT, 32'h1);
        check("masked irq", 32'(clock_gen_irq), 32'h0);
        bus(1, pbcs_pkg::OFS_MASK, 32'h1);
        bus(0, pbcs_pkg::OFS_CTRL, 32'hED);
        bus(0, pbcs_pkg::OFS_CTRL, 32'hAD);
        check("lock irq", 32'(clock_gen_irq), 32'h1);
        bus(1, pbcs_pkg::OFS_STAT, 32'h1);
        bus(0, pbcs_pkg::OFS_STAT, 32'h0);
        check("cleared irq", 32'(clock_gen_irq), 32'h0);
        final_report();
    end
endmodule : test_pll_base_clock_select
`default_nettype wire
